//--- acs_map.svh
// Register offsets, field positions and timing counts of the converter sequencer.
// Assumes a 100 MHz core clock and a byte-addressed register port.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_CHSEL 8'h04
`define ACS_OFF_STAT 8'h08
`define ACS_OFF_DATA 8'h40
`define ACS_STAT_BUSY 0
`define ACS_STAT_JBUSY 1
`define ACS_STAT_STUCK 2
`define ACS_STAT_DONE 3
`define ACS_STAT_CH_LSB 4
`define ACS_DATA_VALID 31
`define ACS_DATA_ABT 30
`define ACS_CTRL_RST 10'h000
`define ACS_CLK_NS 10
`define ACS_SAMPLE_NS 180
`define ACS_CONV_NS 400
`define ACS_SAMPLE_CYC ((`ACS_SAMPLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_CONV_CYC ((`ACS_CONV_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_TMR_W 6
`endif

//--- acs_pkg.sv
// Types shared by the converter sequencer.
// Assumes the offsets and counts of acs_map.svh.
package acs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONV = 4'h4,
    ST_STUCK = 4'h8
  } acs_state_t;
  // Control word, bit 0 is normal_chain_start.
  typedef struct packed {
    logic [3:0] inj_ch;
    logic cross_trigger_unit;
    logic scan;
    logic abort_conv;
    logic chain_abort_bit;
    logic injected_start;
    logic normal_chain_start;
  } acs_ctrl_t;
  typedef struct packed {
    logic valid;
    logic aborted;
    logic [11:0] value;
  } acs_cdata_t;
endpackage : acs_pkg

//--- acs_sequencer.sv
// Conversion sequencer with chain, scan, injected conversions and aborts.
// Assumes a converter that samples while adc_sample_on is high and offers
// adc_result at the end of the conversion phase; timer trigger is synchronous.
//
// Functional notes
// - Abort of one chained conversion after a lone single ends whole chain (silicon).
// - Aborted last conversion shows aborted; silicon still writes its result.
// - Chain abort marks current conversion aborted; silicon still writes result.
// - Injected request during scan chain without cross trigger unit hangs sampling.
// - Chain abort bit terminates the running scan chain.
// - After scan chain abort, next scan repeats first and drops last conversion.
// - Start bits launch conversions; done status bit shows chain completion.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer #(
  parameter bit SILICON_AS_IS = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tmr_ch5_trig,
  input wire logic [11:0] adc_result,
  output logic adc_sample_on,
  output logic [3:0] adc_channel,
  output logic chain_busy
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] next_en(logic [15:0] m, int after);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i] && i > after) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] count_en(logic [15:0] m);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 16; i++) begin
      s = s + 5'(m[i]);
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acs_state_t st_r, st_nxt;
  acs_ctrl_t ctrl_r;
  acs_cdata_t data_r [16];
  logic [15:0] chsel_r;
  logic [`ACS_TMR_W-1:0] tmr_r, tmr_nxt;
  logic [3:0] ch_r, ch_nxt, pos_r, pos_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic chain_r, chain_nxt, inj_r, inj_nxt;
  logic dup_act_r, dup_act_nxt, dup_flag_r, dup_flag_nxt;
  logic single_r, single_nxt, done_r;
  logic data_we, data_abt, data_upd, adv;
  logic clr_ns, clr_js, clr_ab, clr_ac, done_set;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && reg_addr == `ACS_OFF_CTRL;
  wire wr_chsel = reg_wr && reg_addr == `ACS_OFF_CHSEL;
  wire wr_stat = reg_wr && reg_addr == `ACS_OFF_STAT;
  wire hit_data = reg_addr[7:6] == `ACS_OFF_DATA >> 6;
  wire [3:0] rd_idx = reg_addr[5:2];
  wire tmr_hit = tmr_r == '0;
  wire [4:0] chain_len = count_en(chsel_r);
  wire [3:0] first_ch = next_en(chsel_r, -1);
  wire last_conv = cnt_r + 5'h01 == chain_len;
  wire inj_req = ctrl_r.injected_start;
  // A timer hit only counts here when the cross trigger unit does not own it.
  wire tmr_req = tmr_ch5_trig && !ctrl_r.cross_trigger_unit;
  wire hang_inj = SILICON_AS_IS && ctrl_r.scan && !ctrl_r.cross_trigger_unit && inj_req;
  wire run_chain = chain_r && !inj_r && (st_r == ST_SAMPLE || st_r == ST_CONV);
  wire [`ACS_TMR_W-1:0] smp_ld = `ACS_TMR_W'(`ACS_SAMPLE_CYC - 1);
  wire [`ACS_TMR_W-1:0] cnv_ld = `ACS_TMR_W'(`ACS_CONV_CYC - 1);
  wire [31:0] stat_word = {24'h0, ch_r, done_r, st_r == ST_STUCK, inj_r, chain_r};
  wire acs_cdata_t rd_cd = data_r[rd_idx];
  wire [31:0] data_word = {rd_cd.valid, rd_cd.aborted, 18'h0, rd_cd.value};
  wire [31:0] rd_mux =
    reg_addr == `ACS_OFF_CTRL ? {22'h0, ctrl_r} :
    reg_addr == `ACS_OFF_CHSEL ? {16'h0, chsel_r} :
    reg_addr == `ACS_OFF_STAT ? stat_word :
    hit_data ? data_word : 32'h0;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_hit ? tmr_r : tmr_r - `ACS_TMR_W'(1);
    ch_nxt = ch_r;
    pos_nxt = pos_r;
    cnt_nxt = cnt_r;
    chain_nxt = chain_r;
    inj_nxt = inj_r;
    dup_act_nxt = dup_act_r;
    dup_flag_nxt = dup_flag_r;
    single_nxt = single_r;
    data_we = 1'b0;
    data_abt = 1'b0;
    data_upd = 1'b0;
    adv = 1'b0;
    clr_ns = 1'b0;
    clr_js = 1'b0;
    clr_ab = !chain_r;
    clr_ac = !chain_r;
    done_set = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (inj_req) begin
          inj_nxt = 1'b1;
          ch_nxt = ctrl_r.inj_ch;
          clr_js = 1'b1;
          st_nxt = ST_SAMPLE;
          tmr_nxt = smp_ld;
        end else if (ctrl_r.normal_chain_start && |chsel_r) begin
          chain_nxt = 1'b1;
          pos_nxt = first_ch;
          ch_nxt = first_ch;
          cnt_nxt = 5'h00;
          dup_act_nxt = dup_flag_r;
          dup_flag_nxt = 1'b0;
          st_nxt = ST_SAMPLE;
          tmr_nxt = smp_ld;
        end
      end
      ST_SAMPLE, ST_CONV: begin
        if (run_chain && (ctrl_r.chain_abort_bit ||
            (ctrl_r.abort_conv && SILICON_AS_IS && single_r))) begin
          data_we = 1'b1;
          data_abt = 1'b1;
          data_upd = SILICON_AS_IS;
          chain_nxt = 1'b0;
          clr_ab = 1'b1;
          clr_ac = 1'b1;
          dup_flag_nxt = SILICON_AS_IS && ctrl_r.scan;
          st_nxt = ST_IDLE;
        end else if (run_chain && ctrl_r.abort_conv) begin
          clr_ac = 1'b1;
          data_we = 1'b1;
          data_abt = 1'b1;
          data_upd = SILICON_AS_IS && last_conv;
          adv = 1'b1;
        end else if (chain_r && !inj_r && hang_inj) begin
          st_nxt = ST_STUCK;
        end else if (st_r == ST_SAMPLE && tmr_hit) begin
          st_nxt = ST_CONV;
          tmr_nxt = cnv_ld;
        end else if (st_r == ST_CONV && tmr_hit) begin
          data_we = 1'b1;
          data_upd = 1'b1;
          if (inj_r) begin
            inj_nxt = 1'b0;
            ch_nxt = pos_r;
            st_nxt = chain_r ? ST_SAMPLE : ST_IDLE;
            tmr_nxt = smp_ld;
          end else begin
            adv = 1'b1;
          end
        end
      end
      // The converter hangs in sampling; only a reset brings it back.
      ST_STUCK: st_nxt = ST_STUCK;
      default: st_nxt = ST_IDLE;
    endcase
    if (adv) begin
      cnt_nxt = cnt_r + 5'h01;
      st_nxt = ST_SAMPLE;
      tmr_nxt = smp_ld;
      if (last_conv) begin
        done_set = 1'b1;
        single_nxt = chain_len == 5'h01;
        if (ctrl_r.scan && ctrl_r.normal_chain_start) begin
          pos_nxt = first_ch;
          cnt_nxt = 5'h00;
        end else begin
          chain_nxt = 1'b0;
          clr_ns = 1'b1;
          st_nxt = ST_IDLE;
        end
      end else if (dup_act_r) begin
        dup_act_nxt = 1'b0;
      end else begin
        pos_nxt = next_en(chsel_r, int'(pos_r));
      end
      ch_nxt = pos_nxt;
      if (chain_nxt && inj_req) begin
        inj_nxt = 1'b1;
        ch_nxt = ctrl_r.inj_ch;
        clr_js = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      ch_r <= 4'h0;
      pos_r <= 4'h0;
      cnt_r <= 5'h00;
      chain_r <= 1'b0;
      inj_r <= 1'b0;
      dup_act_r <= 1'b0;
      dup_flag_r <= 1'b0;
      single_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      ch_r <= ch_nxt;
      pos_r <= pos_nxt;
      cnt_r <= cnt_nxt;
      chain_r <= chain_nxt;
      inj_r <= inj_nxt;
      dup_act_r <= dup_act_nxt;
      dup_flag_r <= dup_flag_nxt;
      single_r <= single_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Software relies on clearing the start bit with the abort.
  acs_ctrl_t ctrl_hw;
  assign ctrl_hw = '{inj_ch: ctrl_r.inj_ch, cross_trigger_unit: ctrl_r.cross_trigger_unit,
    scan: ctrl_r.scan, abort_conv: ctrl_r.abort_conv && !clr_ac,
    chain_abort_bit: ctrl_r.chain_abort_bit && !clr_ab,
    injected_start: ctrl_r.injected_start && !clr_js,
    normal_chain_start: ctrl_r.normal_chain_start && !clr_ns};
  wire acs_ctrl_t ctrl_sw = reg_wdata[9:0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= `ACS_CTRL_RST;
      chsel_r <= 16'h0000;
      done_r <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      ctrl_r <= wr_ctrl ? ctrl_sw : ctrl_hw;
      ctrl_r.injected_start <= (wr_ctrl ? ctrl_sw.injected_start : ctrl_hw.injected_start)
        || tmr_req;
      chsel_r <= wr_chsel ? reg_wdata[15:0] : chsel_r;
      // A completion in the clearing cycle is kept.
      done_r <= done_set || (done_r && !(wr_stat && reg_wdata[`ACS_STAT_DONE]));
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  for (genvar g = 0; g < 16; g++) begin : g_data
    always_ff @(posedge core_clk) begin
      if (rst) begin
        data_r[g] <= '0;
      end else if (data_we && ch_r == 4'(g)) begin
        data_r[g].aborted <= data_abt;
        data_r[g].valid <= data_r[g].valid || data_upd;
        data_r[g].value <= data_upd ? adc_result : data_r[g].value;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      adc_sample_on <= 1'b0;
      adc_channel <= 4'h0;
      chain_busy <= 1'b0;
    end else begin
      adc_sample_on <= st_nxt == ST_SAMPLE || st_nxt == ST_STUCK;
      adc_channel <= ch_nxt;
      chain_busy <= chain_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire ab_conv_ev = run_chain && ctrl_r.abort_conv && !ctrl_r.chain_abort_bit;
  single_abort_a: assert property (@(posedge core_clk) disable iff (rst)
    ab_conv_ev && SILICON_AS_IS && single_r |=> st_r == ST_IDLE && !chain_busy)
    else $error("lone single abort did not end chain");
  last_abort_data_a: assert property (@(posedge core_clk) disable iff (rst)
    ab_conv_ev && last_conv && !single_r |-> data_we && data_abt
    && data_upd == SILICON_AS_IS)
    else $error("last conversion abort mishandled");
  chain_abort_data_a: assert property (@(posedge core_clk) disable iff (rst)
    run_chain && ctrl_r.chain_abort_bit |-> data_we && data_abt && data_upd == SILICON_AS_IS)
    else $error("chain abort data update wrong");
  stuck_entry_a: assert property (@(posedge core_clk) disable iff (rst)
    run_chain && hang_inj && !ctrl_r.chain_abort_bit && !ctrl_r.abort_conv
    |=> st_r == ST_STUCK ##1 st_r == ST_STUCK && adc_sample_on)
    else $error("injected request did not hang sampling");
  chain_abort_end_a: assert property (@(posedge core_clk) disable iff (rst)
    run_chain && ctrl_r.chain_abort_bit |=> !chain_r ##1 !chain_busy)
    else $error("chain abort did not terminate chain");
  dup_first_a: assert property (@(posedge core_clk) disable iff (rst)
    adv && dup_act_r && !last_conv |=> ch_r == $past(ch_r) || inj_r)
    else $error("first conversion not repeated");
  busy_status_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == `ACS_OFF_STAT |=> reg_rdata[`ACS_STAT_BUSY] == $past(chain_r))
    else $error("busy status does not follow chain");
  chain_order_a: assert property (@(posedge core_clk) disable iff (rst)
    adv && !last_conv && !dup_act_r |=> pos_r > $past(pos_r) && chsel_r[pos_r])
    else $error("chain did not move to next enabled channel");
  conv_time_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(st_r == ST_CONV) |-> tmr_r == cnv_ld)
    else $error("conversion phase length wrong");
  chain_done_c: cover property (@(posedge core_clk) disable iff (rst) done_set);
  stuck_c: cover property (@(posedge core_clk) disable iff (rst) st_r == ST_STUCK);
  chain_abort_c: cover property (@(posedge core_clk) disable iff (rst)
    run_chain && ctrl_r.chain_abort_bit);
  inj_in_chain_c: cover property (@(posedge core_clk) disable iff (rst) inj_r && chain_r);
endmodule : acs_sequencer

//--- acs_adc_model.sv
// Behavioural converter model facing the sequencer's analog side.
// Assumes the sequencer takes adc_result at the end of its conversion phase.
`timescale 1ns/1ps
module acs_adc_model (
  input wire logic core_clk,
  input wire logic adc_sample_on,
  input wire logic [3:0] adc_channel,
  output logic [11:0] adc_result
);
  // ----------------------------------------------------------------------
  // Result generation
  // ----------------------------------------------------------------------
  // While sampling, the output flips every cycle, so a result taken early never matches.
  always_ff @(posedge core_clk) begin
    if (adc_sample_on) begin
      adc_result <= ~adc_result;
    end else begin
      adc_result <= 12'h300 + 12'h011 * adc_channel;
    end
  end
endmodule // acs_adc_model

//--- acs_sequencer_bench.sv
// Self-checking bench for the conversion sequencer.
// Assumes the converter model above and the register map of acs_map.svh.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer_bench;
  import acs_pkg::*;
  logic core_clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic tmr_ch5_trig;
  logic adc_sample_on;
  logic chain_busy;
  logic prev_on;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [11:0] adc_result;
  logic [3:0] adc_channel;
  int num_errors;
  int comparisons;
  int seen_ch[$];

  acs_sequencer u_acs_sequencer (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tmr_ch5_trig(tmr_ch5_trig), .adc_result(adc_result), .adc_sample_on(adc_sample_on),
    .adc_channel(adc_channel), .chain_busy(chain_busy));
  acs_adc_model u_acs_adc_model (.core_clk(core_clk), .adc_sample_on(adc_sample_on),
    .adc_channel(adc_channel), .adc_result(adc_result));

  // ----------------------------------------------------------------------
  // Clock and channel order monitor
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    prev_on <= adc_sample_on;
    if (adc_sample_on === 1'b1 && prev_on !== 1'b1) begin
      seen_ch.push_back(int'(adc_channel));
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_idle(input int maxc, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (chain_busy !== 1'b0 && n < maxc);
    if (chain_busy !== 1'b0) begin
      num_errors++;
      $display("wrong value chain_busy expected 0 seen 1");
      complete_run();
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  function automatic logic [31:0] exp_data(input int ch);
    return 32'h8000_0000 | (32'h300 + 32'h11 * ch);
  endfunction
  function automatic logic [7:0] data_at(input int ch);
    return `ACS_OFF_DATA + 8'(4 * ch);
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int a;
    int b;
    int n;
    logic [31:0] v;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    tmr_ch5_trig = 1'b0;
    void'($urandom(32'h11bcee41));
    do_reset();
    rd(`ACS_OFF_STAT, v);
    check("stat after reset", 32'h0, v);
    rd(`ACS_OFF_CTRL, v);
    check("ctrl after reset", 32'h0, v);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, v);
    check("unmapped read", 32'h0, v);
    $display("test reset and map done");
    a = $urandom_range(0, 14);
    b = $urandom_range(a + 1, 15);
    wr(`ACS_OFF_CHSEL, (32'h1 << a) | (32'h1 << b));
    wr(`ACS_OFF_CTRL, 32'h1);
    @(posedge core_clk);
    #1;
    check("busy at start", 32'h1, 32'(chain_busy));
    wait_idle(400, n);
    check("chain length", 32'(2 * (`ACS_SAMPLE_CYC + `ACS_CONV_CYC)), 32'(n));
    rd(data_at(a), v);
    check("first result", exp_data(a), v);
    rd(data_at(b), v);
    check("second result", exp_data(b), v);
    rd(`ACS_OFF_STAT, v);
    check("done flag", 32'h1, 32'(v[`ACS_STAT_DONE]));
    wr(`ACS_OFF_STAT, 32'h8);
    rd(`ACS_OFF_STAT, v);
    check("done cleared", 32'(b) << `ACS_STAT_CH_LSB, v);
    rd(`ACS_OFF_CTRL, v);
    check("start cleared", 32'h0, v);
    $display("test chain done");
    seen_ch.delete();
    wr(`ACS_OFF_CHSEL, 32'h7);
    wr(`ACS_OFF_CTRL, 32'h11);
    repeat (70) @(posedge core_clk);
    wr(`ACS_OFF_CTRL, 32'h14);
    wait_idle(100, n);
    rd(data_at(1), v);
    check("aborted conversion flags", 32'h3, 32'(v[31:30]));
    check("order before abort", 32'h1, 32'(seen_ch[1]));
    seen_ch.delete();
    wr(`ACS_OFF_CTRL, 32'h11);
    repeat (150) @(posedge core_clk);
    check("scan after abort count", 32'd3, 32'(seen_ch.size()));
    for (int i = 0; i < 3; i++) begin
      check("scan after abort channel", 32'(i / 2), 32'(seen_ch[i]));
    end
    wr(`ACS_OFF_CTRL, 32'h14);
    wait_idle(100, n);
    $display("test chain abort done");
    wr(`ACS_OFF_CHSEL, 32'h1);
    wr(`ACS_OFF_CTRL, 32'h1);
    wait_idle(200, n);
    wr(`ACS_OFF_CHSEL, 32'h6);
    wr(`ACS_OFF_CTRL, 32'h1);
    repeat (10) @(posedge core_clk);
    wr(`ACS_OFF_CTRL, 32'h8);
    wait_idle(30, n);
    check("lone single abort cycles", 32'h1, 32'(n));
    rd(data_at(1), v);
    check("lone single abort flags", 32'h3, 32'(v[31:30]));
    wr(`ACS_OFF_CTRL, 32'h1);
    wait_idle(200, n);
    wr(`ACS_OFF_CTRL, 32'h1);
    repeat (70) @(posedge core_clk);
    wr(`ACS_OFF_CTRL, 32'h8);
    wait_idle(60, n);
    check("last abort cycles", 32'h1, 32'(n));
    rd(data_at(2), v);
    check("aborted last flags", 32'h3, 32'(v[31:30]));
    rd(data_at(1), v);
    check("completed before last", exp_data(1), v);
    $display("test conversion abort done");
    wr(`ACS_OFF_CHSEL, 32'h3);
    wr(`ACS_OFF_CTRL, 32'h11);
    repeat (10) @(posedge core_clk);
    tmr_ch5_trig <= 1'b1;
    @(posedge core_clk);
    tmr_ch5_trig <= 1'b0;
    repeat (100) @(posedge core_clk);
    #1;
    check("hung sampling", 32'h1, 32'(adc_sample_on));
    rd(`ACS_OFF_STAT, v);
    check("hung flag", 32'h1, 32'(v[`ACS_STAT_STUCK]));
    @(posedge core_clk);
    do_reset();
    wr(`ACS_OFF_CTRL, (32'h5 << 6) | 32'h2);
    repeat (70) @(posedge core_clk);
    rd(data_at(5), v);
    check("injected result", exp_data(5), v);
    wr(`ACS_OFF_CTRL, 32'h20);
    @(posedge core_clk);
    tmr_ch5_trig <= 1'b1;
    @(posedge core_clk);
    tmr_ch5_trig <= 1'b0;
    rd(`ACS_OFF_CTRL, v);
    check("timer owned by cross trigger unit", 32'h20, v);
    $display("test injected done");
    complete_run();
  end
endmodule // acs_sequencer_bench
